//--- hdl/nvc_pkg.sv
// shared constants and decoders for the nvm command port
package nvc_pkg;

    // ========================================
    // register offsets
    localparam logic [7:0] NVC_OFS_PTR = 8'h3D;
    localparam logic [7:0] NVC_OFS_VALUE = 8'h3E;
    localparam logic [7:0] NVC_OFS_CMD = 8'h3F;

    // ========================================
    // reset values
    localparam logic [7:0] NVC_PTR_RESET = 8'hC0;
    localparam logic [7:0] NVC_VALUE_RESET = 8'h00;
    localparam logic [7:0] NVC_RDATA_RESET = 8'h00;
    localparam logic [7:0] NVC_CMD_READBACK = 8'h00;

    // ========================================
    // command codes
    localparam logic [7:0] NVC_CMD_UPDATE_ALL = 8'h11;
    localparam logic [7:0] NVC_CMD_REFRESH_ALL = 8'h12;
    localparam logic [7:0] NVC_CMD_WRITE_BYTE = 8'h21;
    localparam logic [7:0] NVC_CMD_READ_BYTE = 8'h22;

    // ========================================
    // protection and image layout
    localparam logic [7:0] NVC_KEY_ENABLE_ON = 8'hFF;
    localparam logic [7:0] NVC_CFG_BASE = 8'hC0;
    localparam int NVC_CFG_COUNT = 16;

    function automatic logic nvc_cmd_legal(input logic [7:0] code);
        return (code == NVC_CMD_UPDATE_ALL) || (code == NVC_CMD_REFRESH_ALL) ||
               (code == NVC_CMD_WRITE_BYTE) || (code == NVC_CMD_READ_BYTE);
    endfunction

    function automatic logic nvc_cmd_is_all(input logic [7:0] code);
        return (code == NVC_CMD_UPDATE_ALL) || (code == NVC_CMD_REFRESH_ALL);
    endfunction

    function automatic logic nvc_cmd_writes(input logic [7:0] code);
        return (code == NVC_CMD_UPDATE_ALL) || (code == NVC_CMD_WRITE_BYTE);
    endfunction

endpackage

//--- hdl/nvc_eng_if.sv
// link between the command register file and the transfer engine
interface nvc_eng_if;
    logic start;
    logic [7:0] cmd;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic busy;
    logic fail;
    logic rd_valid;
    logic [7:0] rd_data;

    modport regs
    (
        output start,
        output cmd,
        output ptr,
        output wdata,
        input busy,
        input fail,
        input rd_valid,
        input rd_data
    );

    modport engine
    (
        input start,
        input cmd,
        input ptr,
        input wdata,
        output busy,
        output fail,
        output rd_valid,
        output rd_data
    );
endinterface

//--- hdl/nvc_engine.sv
// transfer engine: runs one accepted command against the nvm array
module nvc_engine
#(
    parameter int CFG_COUNT = nvc_pkg::NVC_CFG_COUNT
)
(
    input wire logic clk,
    input wire logic rstn,
    nvc_eng_if.engine eng,
    output logic nvm_req,
    output logic nvm_we,
    output logic [7:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic nvm_ack,
    input wire logic nvm_err,
    output logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_rdata,
    output logic cfg_load,
    output logic [7:0] cfg_data
);
    import nvc_pkg::*;

    typedef enum logic {NVC_IDLE, NVC_XFER} nvc_state_t;

    nvc_state_t state;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] cnt;
    logic fail;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] cfg_q;

    wire logic is_all = nvc_cmd_is_all(cmd_q);
    wire logic is_wr = nvc_cmd_writes(cmd_q);
    wire logic is_update = (cmd_q == NVC_CMD_UPDATE_ALL);
    wire logic in_xfer = (state == NVC_XFER);
    wire logic done = nvm_ack && in_xfer;
    wire logic last = !is_all || (cnt == 8'(CFG_COUNT - 1));

    // ========================================
    // nvm side
    // request held until the array acknowledges the last transfer of the command
    assign nvm_req = in_xfer;
    assign nvm_we = in_xfer && is_wr;
    assign nvm_addr = addr_q;
    assign nvm_wdata = is_update ? cfg_rdata : wdata_q;
    assign cfg_addr = addr_q;
    assign cfg_data = cfg_q;
    assign eng.rd_data = rd_data;
    assign eng.rd_valid = rd_valid;
    assign eng.fail = fail;
    assign eng.busy = in_xfer;

    // ========================================
    // sequencer
    // run update, refresh, byte write or read
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= NVC_IDLE;
            cmd_q <= NVC_CMD_READBACK;
            addr_q <= NVC_PTR_RESET;
            wdata_q <= NVC_VALUE_RESET;
            cnt <= 8'h00;
        end
        else if (state == NVC_IDLE && eng.start)
        begin
            state <= NVC_XFER;
            cmd_q <= eng.cmd;
            addr_q <= nvc_cmd_is_all(eng.cmd) ? NVC_CFG_BASE : eng.ptr;
            wdata_q <= eng.wdata;
            cnt <= 8'h00;
        end
        else if (done)
        begin
            state <= last ? NVC_IDLE : NVC_XFER;
            addr_q <= addr_q + 8'h01;
            cnt <= cnt + 8'h01;
        end
    end

    // ========================================
    // results
    // fail is sticky until the next command is taken; no clear can meet a set
    // because a new command is only taken while idle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fail <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= NVC_VALUE_RESET;
            cfg_load <= 1'b0;
            cfg_q <= NVC_VALUE_RESET;
        end
        else
        begin
            rd_valid <= done && (cmd_q == NVC_CMD_READ_BYTE);
            cfg_load <= done && (cmd_q == NVC_CMD_REFRESH_ALL);
            if (done)
            begin
                rd_data <= nvm_rdata;
                cfg_q <= nvm_rdata;
            end
            if (done && is_wr && nvm_err)
                fail <= 1'b1;
            else if (state == NVC_IDLE && eng.start)
                fail <= 1'b0;
        end
    end

    // ========================================
    // checks
    a_start_sets_busy: assert property (@(posedge clk) disable iff (!rstn)
        !eng.busy && eng.start |=> eng.busy)
        else $error("busy did not rise after start");
    a_busy_until_ack: assert property (@(posedge clk) disable iff (!rstn)
        eng.busy && !nvm_ack |=> eng.busy && $stable(nvm_addr))
        else $error("busy dropped without acknowledge");
    a_fail_on_err: assert property (@(posedge clk) disable iff (!rstn)
        nvm_req && nvm_we && nvm_ack && nvm_err |=> eng.fail)
        else $error("write failure not flagged");
    a_read_returns: assert property (@(posedge clk) disable iff (!rstn)
        nvm_req && nvm_ack && cmd_q == NVC_CMD_READ_BYTE
        |=> eng.rd_valid && eng.rd_data == $past(nvm_rdata) && !eng.busy)
        else $error("byte read result missing");
endmodule

//--- hdl/nvc_command_port.sv
// nvm command port: pointer, value and command registers with key protection
// How it works
// - codes start update, refresh, byte write, read
// - fail flag reports failed nvm writes
// - command register reads back zero
// - locked key protection blocks command writes
// - byte commands use pointer and value
// - enabled protection needs matching 32-bit key
module nvc_command_port
#(
    parameter int CFG_COUNT = nvc_pkg::NVC_CFG_COUNT
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic auto_refresh_disable,
    input wire logic [7:0] key_protect_enable,
    input wire logic [31:0] unlock_key,
    input wire logic [31:0] stored_key,
    output logic nvm_busy_flag,
    output logic nvm_write_fail_flag,
    output logic nvm_req,
    output logic nvm_we,
    output logic [7:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic nvm_ack,
    input wire logic nvm_err,
    output logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_rdata,
    output logic cfg_load,
    output logic [7:0] cfg_data
);
    import nvc_pkg::*;

    nvc_eng_if eng ();

    logic [7:0] nvm_byte_pointer;
    logic [7:0] nvm_byte_value;
    logic [7:0] rdata;

    // ========================================
    // decode
    // offset decode shared by the write and read paths
    wire logic sel_ptr = (reg_addr == NVC_OFS_PTR);
    wire logic sel_value = (reg_addr == NVC_OFS_VALUE);
    wire logic sel_cmd = (reg_addr == NVC_OFS_CMD);
    // protection live only when enabled and key differs
    wire logic locked = (key_protect_enable == NVC_KEY_ENABLE_ON) && (unlock_key != stored_key);
    // every write here is key protected
    wire logic wr_ok = reg_wr && !locked;
    wire logic wr_ptr = wr_ok && sel_ptr;
    wire logic wr_value = wr_ok && sel_value;
    wire logic wr_cmd = wr_ok && sel_cmd;
    // other codes, and codes while busy, are dropped
    wire logic cmd_take = wr_cmd && nvc_cmd_legal(reg_wdata) && !eng.busy;
    // auto refresh stays off by host duty alone; a running refresh
    // is never stopped here, so that level is left unread

    // hand accepted code to the engine
    assign eng.start = cmd_take;
    assign eng.cmd = reg_wdata;
    // byte commands take pointer and value
    assign eng.ptr = nvm_byte_pointer;
    assign eng.wdata = nvm_byte_value;

    assign nvm_busy_flag = eng.busy;
    assign nvm_write_fail_flag = eng.fail;
    assign reg_rdata = rdata;

    // command offset reads as zero like any unmapped one
    wire logic [7:0] next_rdata = sel_ptr ? nvm_byte_pointer :
                                  sel_value ? nvm_byte_value :
                                  NVC_CMD_READBACK;

    // ========================================
    // registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            nvm_byte_pointer <= NVC_PTR_RESET;
        else if (wr_ptr)
            nvm_byte_pointer <= reg_wdata;
    end

    // a finished byte read wins over a host write in the same cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            nvm_byte_value <= NVC_VALUE_RESET;
        else if (eng.rd_valid)
            nvm_byte_value <= eng.rd_data;
        else if (wr_value)
            nvm_byte_value <= reg_wdata;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= NVC_RDATA_RESET;
        else if (reg_rd)
            rdata <= next_rdata;
    end

    nvc_engine #(
        .CFG_COUNT(CFG_COUNT)
    ) u_engine (
        .clk(clk),
        .rstn(rstn),
        .eng(eng.engine),
        .nvm_req(nvm_req),
        .nvm_we(nvm_we),
        .nvm_addr(nvm_addr),
        .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata),
        .nvm_ack(nvm_ack),
        .nvm_err(nvm_err),
        .cfg_addr(cfg_addr),
        .cfg_rdata(cfg_rdata),
        .cfg_load(cfg_load),
        .cfg_data(cfg_data)
    );

    // ========================================
    // checks
    a_cmd_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == NVC_OFS_CMD |=> reg_rdata == 8'h00)
        else $error("command register read not zero");

    a_locked_no_start: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && locked |=> !nvm_busy_flag || $past(nvm_busy_flag))
        else $error("locked write started a command");

    a_legal_starts: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && !locked && reg_addr == NVC_OFS_CMD && !nvm_busy_flag
        && nvc_cmd_legal(reg_wdata) |=> nvm_busy_flag ##0 nvm_req)
        else $error("legal command not started");

    a_ptr_feeds_addr: assert property (@(posedge clk) disable iff (!rstn)
        eng.start && reg_wdata == NVC_CMD_WRITE_BYTE
        |=> nvm_addr == $past(nvm_byte_pointer) && nvm_wdata == $past(nvm_byte_value))
        else $error("byte command ignored pointer or value");

    a_key_unlocks: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == NVC_OFS_PTR && key_protect_enable == 8'hFF
        && unlock_key == stored_key |=> nvm_byte_pointer == $past(reg_wdata))
        else $error("unlocked pointer write lost");

    a_key_blocks: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == NVC_OFS_PTR && key_protect_enable == 8'hFF
        && unlock_key != stored_key |=> $stable(nvm_byte_pointer))
        else $error("locked pointer write accepted");

    a_read_fills_value: assert property (@(posedge clk) disable iff (!rstn)
        eng.rd_valid |=> nvm_byte_value == $past(eng.rd_data))
        else $error("byte read not placed in value register");

    // ========================================
    // checks: command gating, results and protection
    a_busy_no_start: assert property (@(posedge clk) disable iff (!rstn)
        nvm_busy_flag
        |-> !eng.start)
        else $error("command taken while busy");

    a_illegal_dropped: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && sel_cmd && !nvc_cmd_legal(reg_wdata) && !nvm_busy_flag
        |=> !nvm_busy_flag && !nvm_req)
        else $error("illegal command code started a transfer");

    a_locked_cmd_drop: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && locked && sel_cmd && !nvm_busy_flag
        |=> !nvm_busy_flag && !nvm_req)
        else $error("locked command write started a transfer");

    a_locked_value: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && locked && sel_value && !eng.rd_valid
        |=> $stable(nvm_byte_value))
        else $error("locked value write accepted");

    a_value_write: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && !locked && sel_value && !eng.rd_valid
        |=> nvm_byte_value == $past(reg_wdata))
        else $error("value write lost");

    a_read_uses_ptr: assert property (@(posedge clk) disable iff (!rstn)
        eng.start && reg_wdata == NVC_CMD_READ_BYTE
        |=> nvm_addr == $past(nvm_byte_pointer) && !nvm_we)
        else $error("byte read used wrong address");

    a_all_from_base: assert property (@(posedge clk) disable iff (!rstn)
        eng.start && nvc_cmd_is_all(reg_wdata)
        |=> nvm_addr == NVC_CFG_BASE && nvm_req)
        else $error("image command did not start at base");

    a_update_writes: assert property (@(posedge clk) disable iff (!rstn)
        eng.start && reg_wdata == NVC_CMD_UPDATE_ALL
        |=> nvm_we && nvm_wdata == cfg_rdata)
        else $error("update did not write the mirror image");

    a_refresh_reads: assert property (@(posedge clk) disable iff (!rstn)
        eng.start && reg_wdata == NVC_CMD_REFRESH_ALL
        |=> nvm_req && !nvm_we)
        else $error("refresh did not read the array");

    a_fail_cleared: assert property (@(posedge clk) disable iff (!rstn)
        eng.start
        |=> !nvm_write_fail_flag)
        else $error("failure flag not cleared by a new command");

    a_fail_sticky: assert property (@(posedge clk) disable iff (!rstn)
        nvm_write_fail_flag && !eng.start
        |=> nvm_write_fail_flag)
        else $error("failure flag dropped on its own");

    a_ptr_reads_back: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && sel_ptr
        |=> reg_rdata == $past(nvm_byte_pointer))
        else $error("pointer read back wrong");
endmodule

//--- verif/nvc_nvm_model.sv
// behavioural nvm array and configuration mirror for the command port
module nvc_nvm_model
(
    input wire logic clk,
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [7:0] nvm_addr,
    input wire logic [7:0] nvm_wdata,
    output logic [7:0] nvm_rdata,
    output logic nvm_ack,
    output logic nvm_err,
    input wire logic [7:0] cfg_addr,
    output logic [7:0] cfg_rdata,
    input wire logic cfg_load,
    input wire logic [7:0] cfg_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] mir [256];
    logic fail_mode = 1'b0;
    int lat = 2;
    int wait_n = 0;
    // ========================================
    // storage and answers
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 8'(i) ^ 8'h3C;
            mir[i] = 8'(i) ^ 8'hA5;
        end
    end
    // released data line shows no stale byte
    assign nvm_rdata = nvm_ack ? mem[nvm_addr] : ~mem[nvm_addr];
    assign nvm_err = nvm_ack & fail_mode;
    assign cfg_rdata = mir[cfg_addr];
    always @(posedge clk)
    begin
        nvm_ack <= 1'b0;
        if (nvm_req && !nvm_ack)
        begin
            wait_n <= wait_n + 1;
            if (wait_n >= lat)
            begin
                nvm_ack <= 1'b1;
                wait_n <= 0;
                if (nvm_we && !fail_mode)
                    mem[nvm_addr] <= nvm_wdata;
            end
        end
        // mirror target trails the stepped address by one
        if (cfg_load)
            mir[cfg_addr - 8'h01] <= cfg_data;
    end
endmodule

//--- verif/testbench.sv
// self-checking bench for the nvm command port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import nvc_pkg::*;
    localparam logic [31:0] KEY = 32'h1234_5678;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] key_protect_enable = 8'h00;
    logic [31:0] unlock_key = 32'h0000_0000;
    logic auto_refresh_disable = 1'b0;
    logic nvm_busy_flag, nvm_write_fail_flag, nvm_req, nvm_we, nvm_ack, nvm_err, cfg_load;
    logic [7:0] reg_rdata, nvm_addr, nvm_wdata, nvm_rdata, cfg_addr, cfg_rdata, cfg_data;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] v;

    always #20 clk = ~clk;

    // small image keeps whole-image commands short
    nvc_command_port #(.CFG_COUNT(2)) i_dut
    (
        .clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .auto_refresh_disable, .key_protect_enable, .unlock_key,
        .stored_key(KEY), .nvm_busy_flag, .nvm_write_fail_flag, .nvm_req,
        .nvm_we, .nvm_addr, .nvm_wdata, .nvm_rdata, .nvm_ack, .nvm_err,
        .cfg_addr, .cfg_rdata, .cfg_load, .cfg_data
    );
    nvc_nvm_model i_nvm
    (
        .clk, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata, .nvm_rdata, .nvm_ack,
        .nvm_err, .cfg_addr, .cfg_rdata, .cfg_load, .cfg_data
    );

    // ========================================
    // access tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic cmd(input logic [7:0] code, input logic busy_exp);
        wr(NVC_OFS_CMD, code);
        @(posedge clk);
        #1 chk("busy", {7'h00, nvm_busy_flag}, {7'h00, busy_exp});
        for (int i = 0; i < 100 && nvm_busy_flag; i++)
            @(posedge clk);
        #1 chk("idle", {7'h00, nvm_busy_flag}, 8'h00);
    endtask
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ========================================
    // tests
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        auto_refresh_disable <= 1'b1;
        rd(NVC_OFS_PTR, v);
        chk("ptr", v, NVC_PTR_RESET);
        rd(NVC_OFS_CMD, v);
        chk("cmd read", v, 8'h00);
        rd(8'h10, v);
        chk("unmapped", v, 8'h00);
        wr(NVC_OFS_VALUE, 8'h5A);
        cmd(NVC_CMD_WRITE_BYTE, 1'b1);
        chk("byte wr", i_nvm.mem[8'hC0], 8'h5A);
        cmd(8'h33, 1'b0);
        wr(NVC_OFS_PTR, 8'hC1);
        cmd(NVC_CMD_READ_BYTE, 1'b1);
        rd(NVC_OFS_VALUE, v);
        chk("byte rd", v, 8'hFD);
        cmd(NVC_CMD_UPDATE_ALL, 1'b1);
        chk("update", i_nvm.mem[8'hC1], 8'h64);
        chk("update end", i_nvm.mem[8'hC2], 8'hFE);
        i_nvm.mem[8'hC0] = 8'h77;
        cmd(NVC_CMD_REFRESH_ALL, 1'b1);
        chk("refresh", i_nvm.mir[8'hC0], 8'h77);
        i_nvm.fail_mode = 1'b1;
        i_nvm.lat = 5;
        cmd(NVC_CMD_WRITE_BYTE, 1'b1);
        chk("fail", {7'h00, nvm_write_fail_flag}, 8'h01);
        i_nvm.fail_mode = 1'b0;
        i_nvm.lat = 0;
        cmd(NVC_CMD_WRITE_BYTE, 1'b1);
        chk("fail clr", {7'h00, nvm_write_fail_flag}, 8'h00);
        @(posedge clk);
        key_protect_enable <= NVC_KEY_ENABLE_ON;
        cmd(NVC_CMD_WRITE_BYTE, 1'b0);
        wr(NVC_OFS_PTR, 8'hC5);
        rd(NVC_OFS_PTR, v);
        chk("locked ptr", v, 8'hC1);
        @(posedge clk);
        unlock_key <= KEY;
        cmd(NVC_CMD_WRITE_BYTE, 1'b1);
        finish_test();
    end

    initial
    begin
        #100us;
        err_count++;
        finish_test();
    end
endmodule
